// *** core/csf_pkg.sv ***
// shared constants for the card status and file coding block
// used by csf_core, csf_text_pack and the bench; no clock or state here
package csf_pkg;
    // status byte values
    localparam logic [7:0] SB_OK = 8'h90;
    localparam logic [7:0] SB_PROACTIVE = 8'h91;
    localparam logic [7:0] SB_MEMORY = 8'h92;
    localparam logic [7:0] SB_BUSY = 8'h93;
    localparam logic [7:0] SB_REFER = 8'h94;
    localparam logic [7:0] SB_SECURITY = 8'h98;
    localparam logic [7:0] SB_DL_ERROR = 8'h9e;
    localparam logic [7:0] SB_LENGTH = 8'h9f;
    localparam logic [7:0] SB_BAD_P3 = 8'h67;
    localparam logic [7:0] SB_BAD_P1P2 = 8'h6b;
    localparam logic [7:0] SB_BAD_INS = 8'h6d;
    localparam logic [7:0] SB_BAD_CLASS = 8'h6e;
    localparam logic [7:0] SB_TECH = 8'h6f;
    localparam logic [7:0] SB2_NONE = 8'h00;
    localparam logic [7:0] SB2_OUT_OF_RANGE = 8'h02;
    localparam logic [7:0] SB2_MEM_PROBLEM = 8'h40;
    localparam logic [7:0] SB2_NOT_FOUND = 8'h04;
    // stored data coding
    localparam logic [7:0] UNASSIGNED_BYTE = 8'hff;
    localparam logic [7:0] LAC_DELETED_BYTE = 8'hfe;
    localparam logic [3:0] PAD_NIBBLE = 4'hf;
    localparam int TEXT_MSB = 7;
    // file identifiers
    localparam logic [15:0] FID_CARD_ID = 16'h2fe2;
    localparam logic [15:0] FID_LANG = 16'h2f05;
    localparam int CARD_ID_BYTES = 10;
    localparam int LANG_ENTRY_BYTES = 2;
    localparam int LANG_ENTRIES = 4;
    localparam int LEGACY_ID_DIGITS = 20;
    localparam int MF_FILE_COUNT = 2;
    // status class columns of the command table
    typedef enum logic [4:0] {
        SC_OK, SC_PRO, SC_DLE, SC_LEN, SC_BUSY, SC_RETRY, SC_MEM,
        SC_NOEF, SC_RANGE, SC_NOTFND, SC_INCONS, SC_NOCHV, SC_ACCESS,
        SC_CHVST, SC_INVST, SC_BLOCKED, SC_MAXVAL, SC_P3, SC_P1P2,
        SC_INS, SC_CLA, SC_TECH
    } csf_class_t;
    localparam int NUM_CLASS = 22;
    // commands in the order of the table
    typedef enum logic [4:0] {
        CMD_SELECT, CMD_STATUS, CMD_UPD_BIN, CMD_UPD_REC, CMD_RD_BIN,
        CMD_RD_REC, CMD_SEEK1, CMD_SEEK2, CMD_INCREASE, CMD_VERIFY,
        CMD_CHANGE, CMD_DISABLE, CMD_ENABLE, CMD_UNBLOCK, CMD_INVAL,
        CMD_REHAB, CMD_RUN_ALG, CMD_SLEEP, CMD_GET_RESP, CMD_TERM_PROF,
        CMD_ENVELOPE, CMD_FETCH, CMD_TERM_RESP
    } csf_cmd_t;
    localparam int NUM_CMD = 23;
    // permitted class mask per command, bit i = class i
    function automatic logic [21:0] csf_allowed(input csf_cmd_t c);
        logic [21:0] m;
        m = 22'h0;
        m[SC_OK] = 1'b1;
        m[SC_MEM] = 1'b1;
        m[SC_P3] = 1'b1;
        m[SC_P1P2] = 1'b1;
        m[SC_CLA] = 1'b1;
        m[SC_TECH] = 1'b1;
        case (c)
            CMD_SELECT, CMD_STATUS: begin
                m[SC_PRO] = 1'b1;
                m[SC_LEN] = 1'b1;
                m[SC_NOTFND] = 1'b1;
            end
            CMD_UPD_BIN, CMD_UPD_REC, CMD_RD_BIN, CMD_RD_REC: begin
                m[SC_PRO] = 1'b1;
                m[SC_RETRY] = (c == CMD_UPD_BIN) || (c == CMD_UPD_REC);
                m[SC_NOEF] = 1'b1;
                m[SC_RANGE] = 1'b1;
                m[SC_INCONS] = 1'b1;
                m[SC_ACCESS] = 1'b1;
                m[SC_INVST] = 1'b1;
            end
            CMD_SEEK1, CMD_SEEK2, CMD_INCREASE: begin
                m[SC_PRO] = 1'b1;
                m[SC_LEN] = (c == CMD_INCREASE);
                m[SC_RETRY] = (c == CMD_INCREASE);
                m[SC_NOEF] = 1'b1;
                m[SC_NOTFND] = 1'b1;
                m[SC_INCONS] = 1'b1;
                m[SC_ACCESS] = 1'b1;
                m[SC_INVST] = 1'b1;
                m[SC_MAXVAL] = (c == CMD_INCREASE);
            end
            CMD_VERIFY, CMD_CHANGE, CMD_DISABLE, CMD_ENABLE,
            CMD_UNBLOCK: begin
                m[SC_PRO] = 1'b1;
                m[SC_RETRY] = 1'b1;
                m[SC_NOCHV] = 1'b1;
                m[SC_ACCESS] = 1'b1;
                m[SC_CHVST] = 1'b1;
                m[SC_BLOCKED] = 1'b1;
            end
            CMD_INVAL, CMD_REHAB: begin
                m[SC_PRO] = 1'b1;
                m[SC_RETRY] = 1'b1;
                m[SC_NOEF] = 1'b1;
                m[SC_ACCESS] = 1'b1;
                m[SC_INVST] = 1'b1;
            end
            CMD_RUN_ALG: begin
                m[SC_LEN] = 1'b1;
                m[SC_INCONS] = 1'b1;
                m[SC_ACCESS] = 1'b1;
            end
            CMD_SLEEP, CMD_GET_RESP: m[SC_PRO] = 1'b1;
            CMD_TERM_PROF, CMD_ENVELOPE: begin
                m[SC_PRO] = 1'b1;
                m[SC_DLE] = (c == CMD_ENVELOPE);
                m[SC_LEN] = (c == CMD_ENVELOPE);
                m[SC_BUSY] = (c == CMD_ENVELOPE);
                m[SC_RETRY] = 1'b1;
            end
            default: begin
                m[SC_PRO] = 1'b1;
                m[SC_RETRY] = 1'b1;
            end
        endcase
        return m;
    endfunction
endpackage

// *** core/csf_text_pack.sv ***
// codes one identification digit pair into one byte and one seven-bit text byte
// purely combinational; csf_core registers every result
`timescale 1ns/100ps
module csf_text_pack
    import csf_pkg::*;
(
    input wire logic [3:0] digit_lo,
    input wire logic [3:0] digit_hi,
    input wire logic lo_valid,
    input wire logic hi_valid,
    input wire logic legacy_order,
    input wire logic [7:0] text_in,
    output logic [7:0] id_byte,
    output logic [7:0] text_byte
);
    logic [3:0] first;
    logic [3:0] second;
    always_comb begin
        first = lo_valid ? digit_lo : PAD_NIBBLE;
        second = hi_valid ? digit_hi : PAD_NIBBLE;
        id_byte = legacy_order ? {first, second} : {second, first};
        text_byte = {1'b0, text_in[TEXT_MSB-1:0]};
    end
endmodule

// *** core/csf_core.sv ***
// status answer generator and master-file store coding for the card
// assumes one request pulse per command from same-clock command logic
`timescale 1ns/100ps
module csf_core
    import csf_pkg::*;
#(
    parameter int ID_DIGITS = 20
)(
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire csf_cmd_t cmd,
    input wire csf_class_t result,
    input wire logic [7:0] result_detail,
    input wire logic [7:0] resp_len,
    input wire logic proactive_pending,
    input wire logic card_toolkit,
    input wire logic term_toolkit,
    input wire logic record_out_of_range,
    input wire logic store_we,
    input wire logic [15:0] store_fid,
    input wire logic [4:0] store_index,
    input wire logic [1:0] store_op,
    input wire logic [7:0] store_data,
    input wire logic [3:0] id_digit_lo,
    input wire logic [3:0] id_digit_hi,
    input wire logic id_lo_valid,
    input wire logic id_hi_valid,
    input wire logic legacy_order,
    input wire logic rd_en,
    input wire logic [15:0] rd_fid,
    input wire logic [4:0] rd_index,
    output logic status_valid,
    output logic [7:0] status_byte_first,
    output logic [7:0] status_byte_second,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic rd_absent
);
    localparam int LANG_BYTES = LANG_ENTRIES * LANG_ENTRY_BYTES;
    localparam logic [1:0] OP_WRITE = 2'd0;
    localparam logic [1:0] OP_CLEAR = 2'd1;
    localparam logic [1:0] OP_DELETE = 2'd2;

    typedef enum logic [1:0] {ST_IDLE, ST_DEFER} csf_seek_t;

    typedef struct packed {
        logic status_valid;
        logic [7:0] sb1;
        logic [7:0] sb2;
        csf_seek_t seek;
        logic [7:0] defer_len;
        logic [CARD_ID_BYTES*8-1:0] id_mem;
        logic [LANG_BYTES*8-1:0] lang_mem;
        logic [LANG_ENTRIES-1:0] lang_used;
        logic rd_valid;
        logic [7:0] rd_data;
        logic rd_absent;
    } csf_state_t;

    csf_state_t s;
    csf_state_t next_s;
    logic [7:0] id_byte;
    logic [7:0] text_byte;
    logic toolkit_ok;
    logic [7:0] sb1_of;
    logic [7:0] sb2_of;
    logic pro_allowed;
    logic [21:0] cmd_allowed;

    csf_text_pack u_pack (
        .digit_lo(id_digit_lo),
        .digit_hi(id_digit_hi),
        .lo_valid(id_lo_valid),
        .hi_valid(id_hi_valid),
        .legacy_order(legacy_order),
        .text_in(store_data),
        .id_byte(id_byte),
        .text_byte(text_byte)
    );

    assign toolkit_ok = card_toolkit && term_toolkit;
    // a function result cannot be bit-selected inside a property
    assign cmd_allowed = csf_allowed(cmd);

    always_comb begin
        csf_class_t cls;
        logic [21:0] allowed;
        logic [7:0] len;
        int bi;
        cls = result;
        allowed = csf_allowed(cmd);
        len = resp_len;
        bi = 0;
        next_s = s;
        next_s.status_valid = 1'b0;
        next_s.rd_valid = 1'b0;
        if (record_out_of_range && cls == SC_P1P2) begin
            cls = SC_RANGE;
        end
        pro_allowed = proactive_pending && toolkit_ok &&
            allowed[SC_PRO] && cmd != CMD_SEEK2;
        // second seek defers the proactive pair
        if (cmd == CMD_GET_RESP && s.seek == ST_DEFER) begin
            pro_allowed = toolkit_ok;
            len = s.defer_len;
        end
        if (cls == SC_OK && pro_allowed) begin
            cls = SC_PRO;
        end
        if ((cls == SC_PRO || cls == SC_BUSY || cls == SC_DLE) &&
            !toolkit_ok) begin
            cls = SC_TECH;
        end
        // fall back to a permitted error
        if (!allowed[cls]) begin
            cls = SC_TECH;
        end
        sb1_of = SB_OK;
        sb2_of = SB2_NONE;
        case (cls)
            SC_OK: begin
                if (len != 8'h00 && allowed[SC_LEN]) begin
                    sb1_of = SB_LENGTH;
                    sb2_of = len;
                end
            end
            SC_PRO: begin
                sb1_of = SB_PROACTIVE;
                sb2_of = len;
            end
            SC_DLE: begin
                sb1_of = SB_DL_ERROR;
                sb2_of = len;
            end
            SC_LEN: begin
                sb1_of = SB_LENGTH;
                sb2_of = len;
            end
            SC_BUSY: sb1_of = SB_BUSY;
            SC_RETRY: begin
                sb1_of = SB_MEMORY;
                sb2_of = {4'h0, result_detail[3:0]};
            end
            SC_MEM: begin
                sb1_of = SB_MEMORY;
                sb2_of = SB2_MEM_PROBLEM;
            end
            SC_NOEF: sb1_of = SB_REFER;
            SC_RANGE: begin
                sb1_of = SB_REFER;
                sb2_of = SB2_OUT_OF_RANGE;
            end
            SC_NOTFND: begin
                sb1_of = SB_REFER;
                sb2_of = SB2_NOT_FOUND;
            end
            SC_INCONS: begin
                sb1_of = SB_REFER;
                sb2_of = 8'h08;
            end
            SC_NOCHV: begin
                sb1_of = SB_SECURITY;
                sb2_of = 8'h02;
            end
            SC_ACCESS: begin
                sb1_of = SB_SECURITY;
                sb2_of = 8'h04;
            end
            SC_CHVST: begin
                sb1_of = SB_SECURITY;
                sb2_of = 8'h08;
            end
            SC_INVST: begin
                sb1_of = SB_SECURITY;
                sb2_of = 8'h10;
            end
            SC_BLOCKED: begin
                sb1_of = SB_SECURITY;
                sb2_of = 8'h40;
            end
            SC_MAXVAL: begin
                sb1_of = SB_SECURITY;
                sb2_of = 8'h50;
            end
            SC_P3: begin
                sb1_of = SB_BAD_P3;
                sb2_of = len;
            end
            SC_P1P2: sb1_of = SB_BAD_P1P2;
            SC_INS: sb1_of = SB_BAD_INS;
            SC_CLA: sb1_of = SB_BAD_CLASS;
            default: sb1_of = SB_TECH;
        endcase
        if (cmd_valid) begin
            next_s.status_valid = 1'b1;
            next_s.sb1 = sb1_of;
            next_s.sb2 = sb2_of;
            if (cmd == CMD_SEEK2 && proactive_pending && toolkit_ok) begin
                next_s.seek = ST_DEFER;
                next_s.defer_len = resp_len;
            end else if (cmd == CMD_GET_RESP) begin
                next_s.seek = ST_IDLE;
            end
        end
        if (store_we && store_fid == FID_CARD_ID &&
            int'(store_index) < CARD_ID_BYTES) begin
            bi = int'(store_index);
            // digits past id length stay padding
            if (2 * bi >= ID_DIGITS) begin
                next_s.id_mem[bi*8 +: 8] = UNASSIGNED_BYTE;
            end else if (store_op == OP_WRITE) begin
                next_s.id_mem[bi*8 +: 8] = id_byte;
            end else begin
                next_s.id_mem[bi*8 +: 8] = UNASSIGNED_BYTE;
            end
        end
        if (store_we && store_fid == FID_LANG &&
            int'(store_index) < LANG_BYTES) begin
            bi = int'(store_index);
            if (store_op == OP_CLEAR) begin
                next_s.lang_mem[bi*8 +: 8] = UNASSIGNED_BYTE;
                next_s.lang_used[bi/LANG_ENTRY_BYTES] = 1'b0;
            end else if (store_op == OP_DELETE) begin
                next_s.lang_mem[bi*8 +: 8] = LAC_DELETED_BYTE;
                next_s.lang_used[bi/LANG_ENTRY_BYTES] = 1'b1;
            end else begin
                next_s.lang_mem[bi*8 +: 8] = text_byte;
                next_s.lang_used[bi/LANG_ENTRY_BYTES] = 1'b1;
            end
        end
        if (rd_en) begin
            next_s.rd_valid = 1'b1;
            next_s.rd_absent = 1'b1;
            next_s.rd_data = UNASSIGNED_BYTE;
            bi = int'(rd_index);
            if (rd_fid == FID_CARD_ID && bi < CARD_ID_BYTES) begin
                next_s.rd_absent = 1'b0;
                next_s.rd_data = s.id_mem[bi*8 +: 8];
            end else if (rd_fid == FID_LANG && bi < LANG_BYTES) begin
                next_s.rd_absent = ~|(s.lang_used >> (bi / LANG_ENTRY_BYTES));
                next_s.rd_data = s.lang_mem[bi*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= '0;
            s.seek <= ST_IDLE;
            s.id_mem <= {CARD_ID_BYTES{UNASSIGNED_BYTE}};
            s.lang_mem <= {LANG_BYTES{UNASSIGNED_BYTE}};
        end else begin
            s <= next_s;
        end
    end

    assign status_valid = s.status_valid;
    assign status_byte_first = s.sb1;
    assign status_byte_second = s.sb2;
    assign rd_valid = s.rd_valid;
    assign rd_data = s.rd_data;
    assign rd_absent = s.rd_absent;

    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);

    a_toolkit_pairs: assert property (
        status_valid && !$past(toolkit_ok) |->
        status_byte_first != SB_PROACTIVE && status_byte_first != SB_BUSY &&
        status_byte_first != SB_DL_ERROR)
        else $error("toolkit status pair without toolkit support");
    a_seek2_defer: assert property (
        cmd_valid && cmd == CMD_SEEK2 |=> status_byte_first != SB_PROACTIVE)
        else $error("second seek answered proactive pending");
    a_normal_end: assert property (
        cmd_valid && result == SC_OK && resp_len == 8'h00 &&
        !proactive_pending && cmd != CMD_GET_RESP |=>
        status_byte_first == SB_OK && status_byte_second == SB2_NONE)
        else $error("success without data not normal ending");
    a_range_status: assert property (
        cmd_valid && record_out_of_range && result == SC_P1P2 &&
        cmd_allowed[SC_RANGE] |=>
        status_byte_first == SB_REFER &&
        status_byte_second == SB2_OUT_OF_RANGE)
        else $error("out of range not reported as referencing");
    a_answer_one: assert property (
        cmd_valid |=> status_valid ##1 !status_valid || $past(cmd_valid))
        else $error("status answer timing wrong");
    a_len_exact: assert property (
        cmd_valid && result == SC_LEN && cmd_allowed[SC_LEN] |=>
        status_byte_second == $past(resp_len))
        else $error("length byte not exact");
    a_text_msb: assert property (
        rd_valid && !rd_absent && $past(rd_fid) == FID_LANG &&
        rd_data != UNASSIGNED_BYTE && rd_data != LAC_DELETED_BYTE |->
        !rd_data[TEXT_MSB])
        else $error("language byte has top bit set");
    a_mf_files: assert property (
        rd_en && rd_fid != FID_CARD_ID && rd_fid != FID_LANG |=>
        rd_absent && rd_data == UNASSIGNED_BYTE)
        else $error("unknown master file answered");
    c_proactive: cover property (
        status_valid && status_byte_first == SB_PROACTIVE);
    c_defer: cover property (s.seek == ST_DEFER ##[1:20] status_valid);
    c_id_read: cover property (rd_valid && !rd_absent && rd_data != 8'hff);
endmodule

// *** tb/csf_term_model.sv ***
// terminal-side model that watches every status answer of the card
// assumes the clock and reset of csf_core and one answer per command
`timescale 1ns/100ps
module csf_term_model
    import csf_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic card_toolkit,
    input wire logic term_toolkit,
    input wire logic status_valid,
    input wire logic [7:0] status_byte_first,
    output logic [7:0] err_count
);
    logic pend_ans;
    logic tk_both;
    logic tk_pair;

    assign tk_pair = (status_byte_first == SB_PROACTIVE) ||
        (status_byte_first == SB_BUSY) || (status_byte_first == SB_DL_ERROR);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pend_ans <= 1'b0;
            tk_both <= 1'b0;
            err_count <= 8'h00;
        end else begin
            pend_ans <= cmd_valid;
            if (cmd_valid) begin
                tk_both <= card_toolkit && term_toolkit;
            end
            if (status_valid != pend_ans) begin
                err_count <= err_count + 8'h01;
            end
            // toolkit pairs only between capable sides
            else if (status_valid && tk_pair && !tk_both) begin
                err_count <= err_count + 8'h01;
            end
        end
    end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for csf_core with a terminal model beside it
// assumes one clock; inputs change on the falling edge only
`timescale 1ns/100ps
module tb_top
    import csf_pkg::*;
;
    logic clk, rstn, cmd_valid, proactive_pending, card_toolkit;
    logic term_toolkit, record_out_of_range, store_we, id_lo_valid;
    logic id_hi_valid, legacy_order, rd_en, status_valid, rd_valid;
    logic rd_absent;
    csf_cmd_t cmd;
    csf_class_t result;
    logic [7:0] result_detail, resp_len, store_data, rd_data, err_count;
    logic [7:0] status_byte_first, status_byte_second;
    logic [15:0] store_fid, rd_fid;
    logic [4:0] store_index, rd_index;
    logic [1:0] store_op;
    logic [3:0] id_digit_lo, id_digit_hi;
    int failures, checks;

    csf_core dut (.clk, .rstn, .cmd_valid, .cmd, .result, .result_detail,
        .resp_len, .proactive_pending, .card_toolkit, .term_toolkit,
        .record_out_of_range, .store_we, .store_fid, .store_index,
        .store_op, .store_data, .id_digit_lo, .id_digit_hi, .id_lo_valid,
        .id_hi_valid, .legacy_order, .rd_en, .rd_fid, .rd_index,
        .status_valid, .status_byte_first, .status_byte_second, .rd_valid,
        .rd_data, .rd_absent);
    csf_term_model u_term (.clk, .rstn, .cmd_valid, .card_toolkit,
        .term_toolkit, .status_valid, .status_byte_first, .err_count);

    task automatic end_sim();
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen,
            input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cmdq(input csf_cmd_t c, input csf_class_t r,
            input logic [7:0] len, input logic [7:0] e1,
            input logic [7:0] e2);
        @(negedge clk);
        cmd = c;
        result = r;
        resp_len = len;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        chk("status_valid", {7'h0, status_valid}, 8'h01);
        chk("status_byte_first", status_byte_first, e1);
        chk("status_byte_second", status_byte_second, e2);
    endtask

    task automatic st(input logic [15:0] f, input logic [4:0] i,
            input logic [1:0] op, input logic [7:0] d);
        @(negedge clk);
        store_fid = f;
        store_index = i;
        store_op = op;
        store_data = d;
        store_we = 1'b1;
        @(negedge clk);
        store_we = 1'b0;
    endtask

    task automatic rd(input logic [15:0] f, input logic [4:0] i,
            input logic [7:0] e, input logic ab);
        @(negedge clk);
        rd_fid = f;
        rd_index = i;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        chk("rd_valid", {7'h0, rd_valid}, 8'h01);
        chk("rd_absent", {7'h0, rd_absent}, {7'h0, ab});
        if (!ab)
            chk("rd_data", rd_data, e);
    endtask

    task automatic t_status();
        cmdq(CMD_SELECT, SC_OK, 8'h00, SB_OK, SB2_NONE);
        cmdq(CMD_SELECT, SC_OK, 8'h1a, SB_LENGTH, 8'h1a);
        cmdq(CMD_SLEEP, SC_LEN, 8'h05, SB_TECH, SB2_NONE);
        cmdq(CMD_RD_BIN, SC_MAXVAL, 8'h00, SB_TECH, SB2_NONE);
        cmdq(CMD_INCREASE, SC_MAXVAL, 8'h00, SB_SECURITY, 8'h50);
        cmdq(CMD_RUN_ALG, SC_MEM, 8'h00, SB_MEMORY, SB2_MEM_PROBLEM);
        result_detail = 8'h03;
        cmdq(CMD_UPD_BIN, SC_RETRY, 8'h00, SB_MEMORY, 8'h03);
        cmdq(CMD_RD_REC, SC_RANGE, 8'h00, SB_REFER,
            SB2_OUT_OF_RANGE);
        cmdq(CMD_RUN_ALG, SC_LEN, 8'h0c, SB_LENGTH, 8'h0c);
        cmdq(CMD_SLEEP, SC_P3, 8'h0a, SB_BAD_P3, 8'h0a);
        cmdq(CMD_VERIFY, SC_NOCHV, 8'h00, SB_SECURITY, 8'h02);
        cmdq(CMD_VERIFY, SC_BLOCKED, 8'h00, SB_SECURITY, 8'h40);
        cmdq(CMD_REHAB, SC_INVST, 8'h00, SB_SECURITY, 8'h10);
        cmdq(CMD_SELECT, SC_NOTFND, 8'h00, SB_REFER, SB2_NOT_FOUND);
        cmdq(CMD_RD_BIN, SC_NOEF, 8'h00, SB_REFER, SB2_NONE);
        cmdq(CMD_STATUS, SC_INS, 8'h00, SB_TECH, SB2_NONE);
        cmdq(CMD_FETCH, SC_CLA, 8'h00, SB_BAD_CLASS, SB2_NONE);
        record_out_of_range = 1'b1;
        cmdq(CMD_RD_REC, SC_P1P2, 8'h00, SB_REFER, SB2_OUT_OF_RANGE);
        record_out_of_range = 1'b0;
    endtask

    task automatic t_toolkit();
        for (int i = 0; i < 4; i++) begin
            card_toolkit = i[0];
            term_toolkit = i[1];
            cmdq(CMD_ENVELOPE, SC_BUSY, 8'h00, (i == 3) ? SB_BUSY : SB_TECH,
                SB2_NONE);
            cmdq(CMD_ENVELOPE, SC_DLE, 8'h07,
                (i == 3) ? SB_DL_ERROR : SB_TECH,
                (i == 3) ? 8'h07 : SB2_NONE);
        end
        cmdq(CMD_FETCH, SC_PRO, 8'h10, SB_PROACTIVE, 8'h10);
        cmdq(CMD_TERM_PROF, SC_DLE, 8'h03, SB_TECH, SB2_NONE);
    endtask

    task automatic t_seek();
        cmdq(CMD_SEEK1, SC_PRO, 8'h0c, SB_PROACTIVE, 8'h0c);
        proactive_pending = 1'b1;
        cmdq(CMD_SEEK2, SC_OK, 8'h14, SB_OK, SB2_NONE);
        proactive_pending = 1'b0;
        cmdq(CMD_GET_RESP, SC_OK, 8'h00, SB_PROACTIVE, 8'h14);
    endtask

    task automatic t_lang();
        rd(FID_LANG, 5'd0, UNASSIGNED_BYTE, 1'b1);
        st(FID_LANG, 5'd0, 2'd0, 8'h65);
        st(FID_LANG, 5'd1, 2'd0, 8'h6e);
        st(FID_LANG, 5'd2, 2'd0, 8'hc4);
        st(FID_LANG, 5'd3, 2'd0, 8'h65);
        rd(FID_LANG, 5'd4, UNASSIGNED_BYTE, 1'b1);
        st(FID_LANG, 5'd6, 2'd0, 8'h64);
        // terminal fetches its broadcast filter language here
        rd(FID_LANG, 5'd0, 8'h65, 1'b0);
        rd(FID_LANG, 5'd1, 8'h6e, 1'b0);
        rd(FID_LANG, 5'd2, 8'h44, 1'b0);
        rd(FID_LANG, 5'd4, UNASSIGNED_BYTE, 1'b0);
        rd(FID_LANG, 5'd5, UNASSIGNED_BYTE, 1'b0);
        st(FID_LANG, 5'd0, 2'd1, 8'h00);
        rd(FID_LANG, 5'd0, UNASSIGNED_BYTE, 1'b0);
        st(FID_LANG, 5'd1, 2'd2, 8'h00);
        rd(FID_LANG, 5'd1, LAC_DELETED_BYTE, 1'b0);
    endtask

    task automatic t_id();
        rd(FID_CARD_ID, 5'd3, UNASSIGNED_BYTE, 1'b0);
        id_digit_lo = 4'h1;
        id_digit_hi = 4'h9;
        st(FID_CARD_ID, 5'd0, 2'd0, 8'h00);
        id_digit_lo = 4'h4;
        id_digit_hi = 4'h5;
        st(FID_CARD_ID, 5'd9, 2'd0, 8'h00);
        legacy_order = 1'b1;
        id_digit_lo = 4'h2;
        id_digit_hi = 4'h3;
        st(FID_CARD_ID, 5'd1, 2'd0, 8'h00);
        legacy_order = 1'b0;
        id_hi_valid = 1'b0;
        id_digit_lo = 4'h7;
        st(FID_CARD_ID, 5'd2, 2'd0, 8'h00);
        id_hi_valid = 1'b1;
        rd(FID_CARD_ID, 5'd0, 8'h91, 1'b0);
        rd(FID_CARD_ID, 5'd1, 8'h23, 1'b0);
        rd(FID_CARD_ID, 5'd2, {PAD_NIBBLE, 4'h7}, 1'b0);
        rd(FID_CARD_ID, 5'd9, 8'h54, 1'b0);
        rd(FID_CARD_ID, 5'd12, UNASSIGNED_BYTE, 1'b1);
        rd(16'h6f07, 5'd0, UNASSIGNED_BYTE, 1'b1);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #400000;
        failures++;
        end_sim();
    end

    initial begin
        {rstn, cmd_valid, proactive_pending, record_out_of_range} = 4'h0;
        {store_we, legacy_order, rd_en} = 3'h0;
        {card_toolkit, term_toolkit, id_lo_valid, id_hi_valid} = 4'hf;
        cmd = CMD_SELECT;
        result = SC_OK;
        {result_detail, resp_len, store_data} = 24'h0;
        {store_fid, rd_fid, store_index, rd_index, store_op} = 44'h0;
        {id_digit_lo, id_digit_hi} = 8'h0;
        failures = 0;
        checks = 0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        chk("status_valid", {7'h0, status_valid}, 8'h00);
        t_status();
        t_toolkit();
        t_seek();
        t_lang();
        t_id();
        @(negedge clk);
        chk("err_count", err_count, 8'h00);
        end_sim();
    end
endmodule
